/* File: common/jcr_pkg.sv */
package jcr_pkg;
  localparam int IR_W = 6;
  localparam int WORD_W = 16;
  localparam int CNT_W = 4;
  localparam logic [IR_W-1:0] IR_CFG_IN = 6'h05;
  localparam logic [IR_W-1:0] IR_CFG_OUT = 6'h04;
  localparam logic [IR_W-1:0] IR_BYPASS = 6'h3F;
  localparam logic [IR_W-1:0] IR_CAPTURE = 6'h01;
  localparam logic [CNT_W-1:0] LAST_BIT = 4'hF;
  localparam logic [WORD_W-1:0] SYNC_HI = 16'hAA99;
  localparam logic [WORD_W-1:0] SYNC_LO = 16'h5566;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  // Type 1 header: [15:13] type, [12:11] opcode, [10:5] register address, [4:0] word count.
  localparam int HDR_TYPE_HI = 15;
  localparam int HDR_TYPE_LO = 13;
  localparam int HDR_OP_HI = 12;
  localparam int HDR_OP_LO = 11;
  localparam int HDR_ADDR_HI = 10;
  localparam int HDR_ADDR_LO = 5;
  localparam int HDR_CNT_HI = 4;
  localparam int HDR_CNT_LO = 0;
  localparam logic [2:0] HDR_TYPE1 = 3'h1;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [5:0] ADDR_STATUS = 6'h08;
  localparam logic [5:0] ADDR_COW = 6'h09;
  localparam logic [WORD_W-1:0] COW_RESET = 16'h0000;
  localparam logic [4:0] WCNT_ZERO = 5'h00;
  localparam logic [4:0] WCNT_ONE = 5'h01;

  typedef enum logic [15:0] {
    TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SEL_DR = 16'h0004, TAP_CAP_DR = 16'h0008,
    TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020, TAP_PA_DR = 16'h0040, TAP_EX2_DR = 16'h0080,
    TAP_UP_DR = 16'h0100, TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PA_IR = 16'h2000, TAP_EX2_IR = 16'h4000, TAP_UP_IR = 16'h8000
  } jcr_tap_type;

  typedef enum logic [3:0] {
    PK_HUNT = 4'h1, PK_SYNC2 = 4'h2, PK_HDR = 4'h4, PK_WDATA = 4'h8
  } jcr_pkt_type;
endpackage

/* File: src/jcr_sync3.sv */
`timescale 1ns/1ps
// Three-stage synchroniser; the output moves only when stages two and three agree.
module jcr_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  wire agree = (s2_r == s3_r);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree) begin
        q <= s3_r;
      end
    end
  end
endmodule

/* File: src/jcr_readback.sv */
`timescale 1ns/1ps
module jcr_readback (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [jcr_pkg::WORD_W-1:0] status_in,
  output logic [jcr_pkg::WORD_W-1:0] config_option_word,
  output logic synced
);
  import jcr_pkg::*;

  // Link side, clocked by tck.
  jcr_tap_type st_r;
  jcr_tap_type st_nxt;
  logic [IR_W-1:0] ir_r;
  logic [IR_W-1:0] ir_sr_r;
  logic [WORD_W-1:0] in_sr_r;
  logic [WORD_W-1:0] word_r;
  logic word_tgl_r;
  logic [CNT_W-1:0] bit_cnt_r;
  logic [WORD_W-1:0] out_word_r;
  logic [WORD_W-1:0] out_sr_r;
  logic byp_r;
  logic rb_tgl_seen_r;
  logic rb_tgl_tck;
  logic [WORD_W-1:0] rb_word_r;

  always_comb begin
    unique case (st_r)
      TAP_TLR: st_nxt = tms ? TAP_TLR : TAP_RTI;
      TAP_RTI: st_nxt = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: st_nxt = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: st_nxt = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: st_nxt = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: st_nxt = tms ? TAP_UP_DR : TAP_PA_DR;
      TAP_PA_DR: st_nxt = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: st_nxt = tms ? TAP_UP_DR : TAP_SH_DR;
      TAP_UP_DR: st_nxt = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: st_nxt = tms ? TAP_TLR : TAP_CAP_IR;
      TAP_CAP_IR: st_nxt = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: st_nxt = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: st_nxt = tms ? TAP_UP_IR : TAP_PA_IR;
      TAP_PA_IR: st_nxt = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: st_nxt = tms ? TAP_UP_IR : TAP_SH_IR;
      TAP_UP_IR: st_nxt = tms ? TAP_SEL_DR : TAP_RTI;
      default: st_nxt = TAP_TLR;
    endcase
  end

  wire sel_in = (ir_r == IR_CFG_IN);
  wire sel_out = (ir_r == IR_CFG_OUT);
  wire in_shift = (st_r == TAP_SH_DR) && sel_in;
  wire out_shift = (st_r == TAP_SH_DR) && sel_out;
  wire out_capture = (st_r == TAP_CAP_DR) && sel_out;
  wire word_done = in_shift && (bit_cnt_r == LAST_BIT);
  wire [WORD_W-1:0] in_next = {in_sr_r[WORD_W-2:0], tdi};
  wire rb_arrived = (rb_tgl_tck != rb_tgl_seen_r);

  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      st_r <= TAP_TLR;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      ir_r <= IR_BYPASS;
      ir_sr_r <= IR_CAPTURE;
    end else if (st_r == TAP_TLR) begin
      ir_r <= IR_BYPASS;
    end else if (st_r == TAP_CAP_IR) begin
      ir_sr_r <= IR_CAPTURE;
    end else if (st_r == TAP_SH_IR) begin
      ir_sr_r <= {tdi, ir_sr_r[IR_W-1:1]};
    end else if (st_r == TAP_UP_IR) begin
      ir_r <= ir_sr_r;
    end
  end

  // A word is handed over every sixteenth shift, including the one taken on the exit edge.
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      in_sr_r <= WORD_ZERO;
      bit_cnt_r <= '0;
      word_r <= WORD_ZERO;
      word_tgl_r <= 1'b0;
    end else if (st_r == TAP_CAP_DR) begin
      bit_cnt_r <= '0;
    end else if (in_shift) begin
      in_sr_r <= in_next;
      bit_cnt_r <= bit_cnt_r + 1'b1;
      if (word_done) begin
        word_r <= in_next;
        word_tgl_r <= ~word_tgl_r;
      end
    end
  end

  // The readback word is latched here so that a later capture never samples a word in flight.
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      rb_tgl_seen_r <= 1'b0;
      out_word_r <= WORD_ZERO;
      out_sr_r <= WORD_ZERO;
      byp_r <= 1'b0;
    end else begin
      if (rb_arrived) begin
        rb_tgl_seen_r <= rb_tgl_tck;
        out_word_r <= rb_word_r;
      end
      if (out_capture) begin
        out_sr_r <= out_word_r;
      end else if (out_shift) begin
        out_sr_r <= {out_sr_r[WORD_W-2:0], 1'b0};
      end
      byp_r <= (st_r == TAP_SH_DR) ? tdi : 1'b0;
    end
  end

  wire tdo_sel = (st_r == TAP_SH_IR) ? ir_sr_r[0] : (sel_out ? out_sr_r[WORD_W-1] : (sel_in ? 1'b0 : byp_r));
  wire tdo_drive = (st_r == TAP_SH_IR) || (st_r == TAP_SH_DR);

  // TDO changes on the falling edge so the host sees a half period of setup.
  always_ff @(negedge tck or posedge rst) begin
    if (rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo <= tdo_sel;
      tdo_oe <= tdo_drive;
    end
  end

  // Core side, clocked by core_clk, apart from the readback toggle synchroniser, which runs on tck.
  jcr_pkt_type pst_r;
  jcr_pkt_type pst_nxt;
  logic word_tgl_core;
  logic word_seen_r;
  logic rb_tgl_r;
  logic [5:0] waddr_r;
  logic [4:0] wcnt_r;
  logic [WORD_W-1:0] cow_r;

  jcr_sync3 #(.W(1)) u_word_sync (
    .clk(core_clk),
    .rst(rst),
    .d(word_tgl_r),
    .q(word_tgl_core)
  );

  jcr_sync3 #(.W(1)) u_rb_sync (
    .clk(tck),
    .rst(rst),
    .d(rb_tgl_r),
    .q(rb_tgl_tck)
  );

  // The word stays still for sixteen tck periods, far longer than the toggle takes to cross.
  wire word_evt = (word_tgl_core != word_seen_r);
  wire [WORD_W-1:0] pw = word_r;
  wire hdr_t1 = (pw[HDR_TYPE_HI:HDR_TYPE_LO] == HDR_TYPE1);
  wire [1:0] hdr_op = pw[HDR_OP_HI:HDR_OP_LO];
  wire [5:0] hdr_addr = pw[HDR_ADDR_HI:HDR_ADDR_LO];
  wire [4:0] hdr_cnt = pw[HDR_CNT_HI:HDR_CNT_LO];
  wire hdr_rd = word_evt && (pst_r == PK_HDR) && hdr_t1 && (hdr_op == OP_READ);
  wire hdr_wr = word_evt && (pst_r == PK_HDR) && hdr_t1 && (hdr_op == OP_WRITE) && (hdr_cnt != WCNT_ZERO);
  wire rd_ok = (hdr_addr == ADDR_STATUS) || (hdr_addr == ADDR_COW);
  wire [WORD_W-1:0] rd_data = (hdr_addr == ADDR_STATUS) ? status_in : cow_r;
  wire wr_evt = word_evt && (pst_r == PK_WDATA);

  always_comb begin
    pst_nxt = pst_r;
    if (word_evt) begin
      unique case (pst_r)
        PK_HUNT: pst_nxt = (pw == SYNC_HI) ? PK_SYNC2 : PK_HUNT;
        PK_SYNC2: pst_nxt = (pw == SYNC_LO) ? PK_HDR : PK_HUNT;
        PK_HDR: pst_nxt = hdr_wr ? PK_WDATA : PK_HDR;
        PK_WDATA: pst_nxt = (wcnt_r == WCNT_ONE) ? PK_HDR : PK_WDATA;
        default: pst_nxt = PK_HUNT;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pst_r <= PK_HUNT;
      word_seen_r <= 1'b0;
    end else begin
      pst_r <= pst_nxt;
      word_seen_r <= word_tgl_core;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rb_word_r <= WORD_ZERO;
      rb_tgl_r <= 1'b0;
    end else if (hdr_rd && rd_ok) begin
      rb_word_r <= rd_data;
      rb_tgl_r <= ~rb_tgl_r;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      waddr_r <= '0;
      wcnt_r <= WCNT_ZERO;
      cow_r <= COW_RESET;
    end else if (hdr_wr) begin
      waddr_r <= hdr_addr;
      wcnt_r <= hdr_cnt;
    end else if (wr_evt) begin
      wcnt_r <= wcnt_r - 1'b1;
      if (waddr_r == ADDR_COW) begin
        cow_r <= pw;
      end
    end
  end

  assign config_option_word = cow_r;
  assign synced = (pst_r == PK_HDR) || (pst_r == PK_WDATA);

  word_handoff_a: assert property (@(posedge tck) disable iff (rst)
    word_done |=> (word_tgl_r != $past(word_tgl_r)) && (bit_cnt_r == '0))
    else $error("input word not handed over after sixteen bits");
  msb_first_a: assert property (@(posedge tck) disable iff (rst)
    word_done |=> word_r == {$past(in_sr_r[WORD_W-2:0]), $past(tdi)})
    else $error("input word not assembled MSB first");
  out_capture_a: assert property (@(posedge tck) disable iff (rst)
    out_capture ##1 out_shift |-> out_sr_r == $past(out_word_r, 1))
    else $error("readback word not captured");
  out_shift_a: assert property (@(posedge tck) disable iff (rst)
    out_shift |=> out_sr_r == {$past(out_sr_r[WORD_W-2:0]), 1'b0})
    else $error("readback word not shifted MSB first");
  tdo_drive_a: assert property (@(posedge tck) disable iff (rst)
    (st_r == TAP_SH_DR) |-> tdo_oe)
    else $error("tdo not driven in shift state");
  status_read_a: assert property (@(posedge core_clk) disable iff (rst)
    (hdr_rd && hdr_addr == ADDR_STATUS) |=> (rb_word_r == $past(status_in)) && (rb_tgl_r != $past(rb_tgl_r)))
    else $error("status read header did not load readback word");
  nosync_read_a: assert property (@(posedge core_clk) disable iff (rst)
    (word_evt && !synced) |=> (rb_tgl_r == $past(rb_tgl_r)) && (pst_r != PK_WDATA))
    else $error("packet acted on before synchronisation");
  word_reach_a: assert property (@(posedge core_clk) disable iff (rst)
    $changed(word_tgl_r) |-> ##[1:12] (word_seen_r == word_tgl_r))
    else $error("input word never reached the packet processor");

  sync_seen_c: cover property (@(posedge core_clk) disable iff (rst) (pst_r == PK_SYNC2) ##[1:200] synced);
  status_rd_c: cover property (@(posedge core_clk) disable iff (rst) hdr_rd && hdr_addr == ADDR_STATUS);
  readout_c: cover property (@(posedge tck) disable iff (rst) out_capture ##1 out_shift [*8]);
endmodule

/* File: sim/jcr_host.sv */
`timescale 1ns/1ps
module jcr_host
  import jcr_pkg::*;
(
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One link cycle of 160 ns; the clock rests low between frames.
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #80;
    q = tdo;
    tck = 1'b1;
    #80;
    tck = 1'b0;
  endtask

  // Data is a don't-care here, so it toggles rather than holding a stale bit.
  task automatic idle(input int n, input logic m);
    logic q;
    repeat (n) step(m, ~tdi, q);
  endtask

  task automatic ir(input logic [IR_W-1:0] code);
    logic q;
    for (int i = 0; i < IR_W; i++) step(i == IR_W - 1, code[i], q);
  endtask

  task automatic dr(input logic [WORD_W-1:0] w, input logic last, output logic [WORD_W-1:0] got);
    for (int i = WORD_W - 1; i >= 0; i--) step(last && i == 0, w[i], got[i]);
  endtask

  task automatic run(input logic [WORD_W-1:0] w[$], output logic [WORD_W-1:0] rd);
    logic [WORD_W-1:0] junk;
    idle(5, 1'b1);
    idle(1, 1'b0);
    idle(2, 1'b1);
    idle(2, 1'b0);
    ir(IR_CFG_IN);
    idle(2, 1'b1);
    idle(2, 1'b0);
    foreach (w[i]) dr(w[i], i == w.size() - 1, junk);
    idle(3, 1'b1);
    idle(2, 1'b0);
    ir(IR_CFG_OUT);
    idle(2, 1'b1);
    idle(2, 1'b0);
    dr(16'h5A5A, 1'b1, rd);
    idle(3, 1'b1);
    idle(2, 1'b0);
    idle(5, 1'b1);
  endtask
endmodule

/* File: sim/jcr_readback_tb.sv */
`timescale 1ns/1ps
module jcr_readback_tb;
  import jcr_pkg::*;
  typedef logic [15:0] jcr_wq_type [$];
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic synced;
  logic [WORD_W-1:0] status_in = 16'h0000;
  logic [WORD_W-1:0] config_option_word;
  logic [WORD_W-1:0] rd;
  logic [WORD_W-1:0] cow_exp;
  logic [31:0] seed = 32'h5B430571;
  int failures = 0;
  int n_checks = 0;

  always #2 core_clk = ~core_clk;

  jcr_readback jcr_readback_inst (
    .core_clk(core_clk),
    .rst(rst),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo),
    .tdo_oe(tdo_oe),
    .status_in(status_in),
    .config_option_word(config_option_word),
    .synced(synced)
  );

  jcr_host jcr_host_inst (
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [15:0] hdr(input logic [1:0] op, input logic [5:0] addr, input logic [4:0] cnt);
    return {HDR_TYPE1, op, addr, cnt};
  endfunction

  // Pads every stream with filler to ten words, 159 shifts plus the exit bit.
  function automatic jcr_wq_type stream(input jcr_wq_type pre);
    jcr_wq_type q;
    q = pre;
    while (q.size() < 10) q.push_back(16'h2000);
    return q;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    jcr_host_inst.run(stream('{16'h2901, hdr(OP_WRITE, ADDR_COW, WCNT_ONE), 16'h1234}), rd);
    check("synced", {15'h0, synced}, 16'h0000);
    check("option word", config_option_word, COW_RESET);
    $display("test unsynced done");
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      @(negedge core_clk);
      status_in = (k == 0) ? 16'h8001 : seed[15:0];
      jcr_host_inst.run(stream('{SYNC_HI, SYNC_LO, 16'h2901}), rd);
      check("status", rd, status_in);
      check("synced", {15'h0, synced}, 16'h0001);
    end
    $display("test status done");
    seed = lfsr(seed);
    cow_exp = seed[15:0];
    jcr_host_inst.run(stream('{SYNC_HI, SYNC_LO, hdr(OP_WRITE, ADDR_COW, WCNT_ONE), cow_exp,
                               hdr(OP_READ, ADDR_COW, WCNT_ONE)}), rd);
    check("option word", config_option_word, cow_exp);
    check("option read", rd, cow_exp);
    $display("test option done");
    @(negedge core_clk);
    status_in = ~cow_exp;
    jcr_host_inst.run(stream('{SYNC_HI, SYNC_LO, hdr(OP_READ, 6'h00, WCNT_ONE)}), rd);
    check("kept word", rd, cow_exp);
    check("oe idle", {15'h0, tdo_oe}, 16'h0000);
    $display("test unmapped done");
    test_done();
  end

  // Seven readback frames need about 248 us of link time; the limit keeps the run near 75000 core cycles.
  initial begin
    #300000;
    failures++;
    test_done();
  end
endmodule
